/* rtl/lpb_pkg.sv */
// Constants, types and state codes for the line printer buffer
package lpb_pkg;
  localparam int COLS = 64; // Columns in the core plane
  localparam int HAM = 120; // Hammer lines toward the printer
  localparam int HAM_HI = 56; // Hammers fed from the second output row
  localparam int PLUGS = 15; // Tab plug sockets
  localparam logic [6:0] LINE_END = 7'h78; // Imaginary position 121, zero based
  localparam logic [6:0] HALF = 7'h40; // First position of the second half
  localparam logic [5:0] LAST_COL = 6'h3f; // Last column of a scan
  localparam logic [3:0] LAST_TAB = 4'hf; // Sixteenth tab in a line
  localparam int ROW_LO = 14; // Output row for positions 1 to 64
  localparam int ROW_HI = 15; // Output row for positions 65 to 120
  // Character codes that steer read-in
  localparam logic [5:0] CODE_TAB = 6'h03;
  localparam logic [5:0] CODE_CR = 6'h04;
  localparam logic [5:0] CODE_SPACE = 6'h05;
  localparam logic [5:0] CODE_STOP = 6'h2f;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PLUG = 8'h40;
  localparam logic [7:0] OFS_PLUG_END = 8'h7c;
  // Control register fields
  localparam int CT_PFM = 0;
  localparam int CT_DBL = 1;
  localparam int CT_LPP = 2;
  localparam int CT_EXTRA = 8;
  localparam logic [9:0] CTRL_RST = 10'h000;
  // Synchroniser lanes for printer and panel pins
  localparam int SY_CHAR = 0;
  localparam int SY_REV = 1;
  localparam int SY_LINE = 2;
  localparam int SY_MOVE = 3;
  localparam int SY_MAN = 4;
  // Sequence register: octal flip-flop patterns per phase
  typedef enum logic [6:0] {
    S500_CLEAR = 7'h00, S501_FIRST = 7'h01, S502_WAIT = 7'h05,
    S503_READ = 7'h15, S504_WRITE = 7'h14,
    S600_REST = 7'h20, S601_SCAN = 7'h21, S602_BACK = 7'h23,
    S603_FIRE = 7'h22, S604_CHECK = 7'h26,
    S700_SET = 7'h40, S701_RUN = 7'h41,
    S800_SET = 7'h50, S801_RUN = 7'h51, S802_HALT = 7'h53,
    S900_SET = 7'h60, S901_RUN = 7'h61
  } lpb_state_t;
  // Character as it arrives from the converter
  typedef struct packed {
    logic [5:0] code;
    logic ctl;
    logic par;
  } lpb_in_char_t;
  // Character as stored: merged parity over code
  typedef struct packed {
    logic par;
    logic [5:0] code;
  } lpb_char_t;
endpackage

/* rtl/lpb_top.sv */
// Line printer buffer: core line store, print sequencing and paper feed
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lpb_top import lpb_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire lpb_in_char_t char_in,
  input wire logic char_valid_in,
  output logic char_ready_out,
  input wire logic char_sync_in,
  input wire logic rev_sync_in,
  input wire logic line_fed_in,
  input wire logic paper_moving_in,
  input wire logic manual_reset_in,
  output logic feed_out,
  output logic [HAM-1:0] hammer_out
);
  lpb_state_t state_reg, state_next; // Sequence register
  logic [15:0] mem [COLS]; // Core plane, bits 15:14 output rows
  logic [13:0] isr_reg; // Input static register
  logic [1:0] ofr_reg; // Output flag register
  logic [6:0] col_reg; // Column selector, zero based position
  logic [5:0] idx_reg; // Scan column for clear and print
  logic [3:0] tab_reg; // Tab counter
  logic [5:0] drum_reg; // Drum position counter
  logic [5:0] drum_next; // Drum position after this edge
  logic [5:0] first_reg; // First character register
  logic [5:0] lc_reg; // Line counter
  logic [5:0] rem_reg; // Lines still to feed
  logic [5:0] pfc_reg; // Programmed feed count
  logic page_reg, tail_reg, stop_reg, alarm_reg;
  lpb_char_t ch_reg; // Character being stored
  logic [HAM-1:0] hammer_reg;
  logic [4:0] s1_reg, s2_reg, s3_reg; // Pin synchronisers
  logic [4:0] rise;
  logic [9:0] ctrl_reg; // Mode and page switches
  logic [6:0] plug_reg [PLUGS]; // Tab plug labels, 0 means empty
  logic [31:0] rdata_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic take, pfm, accept, lf, bottom, fin;
  logic [5:0] lc_inc;
  lpb_char_t in_ch;

  // Column of a line position
  function automatic logic [5:0] col_of(input logic [6:0] pos);
    col_of = pos[5:0];
  endfunction

  // Stored character matches code; empty slots never print
  function automatic logic hit(input logic [6:0] c, input logic [5:0] code);
    hit = (c[5:0] == code) && (c != 7'h00);
  endfunction

  // Register read decode
  function automatic logic [31:0] rd_mux(input logic [31:0] a);
    rd_mux = 32'h0000_0000;
    if (a[31:8] != 24'h00_0000) begin
      rd_mux = 32'h0000_0000;
    end else if (a[7:0] == OFS_CTRL) begin
      rd_mux = {22'h00_0000, ctrl_reg};
    end else if (a[7:0] == OFS_STAT) begin
      rd_mux = {1'b0, col_reg, 2'h0, alarm_reg, stop_reg, tab_reg, 2'h0, lc_reg,
                1'b0, state_reg};
    end else if (a[7:0] >= OFS_PLUG && a[7:0] < OFS_PLUG_END && a[1:0] == 2'h0) begin
      rd_mux = {25'h000_0000, plug_reg[4'(a[7:2] - OFS_PLUG[7:2])]};
    end
  endfunction

  assign pfm = ctrl_reg[CT_PFM];
  assign rise = s2_reg & ~s3_reg;
  assign lf = rise[SY_LINE];
  // Revolution pulse resyncs; shared by the counter and the first-character copy
  assign drum_next = rise[SY_REV] ? 6'h00 : (rise[SY_CHAR] ? drum_reg + 6'h01 : drum_reg);
  assign in_ch = '{par: char_in.ctl ^ char_in.par, code: char_in.code};
  assign char_ready_out = (state_reg == S501_FIRST) ||
                          (state_reg == S502_WAIT && col_reg < LINE_END);
  assign accept = char_ready_out && char_valid_in;
  assign lc_inc = lc_reg + 6'h01;
  assign bottom = !tail_reg && lc_inc == ctrl_reg[CT_LPP +: 6];
  assign fin = lf && (tail_reg ? rem_reg == 6'h01 : (!bottom && !page_reg && rem_reg == 6'h01));
  assign feed_out = state_reg == S701_RUN || state_reg == S801_RUN || state_reg == S901_RUN;
  assign hammer_out = hammer_reg;
  assign hrdata_out = rdata_reg;
  assign hreadyout_out = 1'b1; // Zero wait states
  assign hresp_out = 1'b0; // Always OKAY
  assign take = hsel_in && hready_in && htrans_in[1];

  // Two flops per pin, third flop only for edge finding
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
      s3_reg <= 5'h00;
    end else begin
      s1_reg <= {manual_reset_in, paper_moving_in, line_fed_in, rev_sync_in, char_sync_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Next state of the sequence register
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S500_CLEAR: begin
        if (idx_reg == LAST_COL) state_next = pfm ? S501_FIRST : S502_WAIT;
      end
      S501_FIRST: begin
        if (accept) state_next = S502_WAIT;
      end
      S502_WAIT: begin
        if (col_reg >= LINE_END) begin
          state_next = pfm ? S900_SET : S600_REST;
        end else if (accept) begin
          if (in_ch.code == CODE_CR || in_ch.code == CODE_STOP) begin
            state_next = pfm ? S900_SET : S600_REST;
          end else if (in_ch.code > CODE_SPACE && in_ch.code != 6'h3f) begin
            state_next = S503_READ;
          end
        end
      end
      S503_READ: state_next = S504_WRITE;
      S504_WRITE: state_next = S502_WAIT;
      S600_REST: begin
        // Start on a drum sync so the 128-cycle pass never straddles one
        if (!s2_reg[SY_MOVE] && rise[SY_CHAR]) state_next = S601_SCAN;
      end
      S601_SCAN: state_next = S602_BACK;
      S602_BACK: state_next = (idx_reg == LAST_COL) ? S603_FIRE : S601_SCAN;
      S603_FIRE: begin
        if (rise[SY_CHAR]) state_next = S604_CHECK;
      end
      S604_CHECK: begin
        if (drum_reg != first_reg) begin
          state_next = S601_SCAN;
        end else if (stop_reg) begin
          state_next = S800_SET;
        end else begin
          state_next = pfm ? S500_CLEAR : S700_SET;
        end
      end
      S700_SET: state_next = S701_RUN;
      S701_RUN: begin
        if (fin) state_next = S500_CLEAR;
      end
      S800_SET: state_next = S801_RUN;
      S801_RUN: begin
        if (fin) state_next = S802_HALT;
      end
      S802_HALT: begin
        if (rise[SY_MAN]) state_next = S500_CLEAR;
      end
      S900_SET: state_next = (pfc_reg == 6'h00) ? S600_REST : S901_RUN;
      S901_RUN: begin
        if (fin) state_next = S600_REST;
      end
      default: state_next = S500_CLEAR;
    endcase
  end

  // Sequence register, codes are the flop patterns
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) state_reg <= S500_CLEAR;
    else state_reg <= state_next;
  end

  // Read-in bookkeeping: column, tabs, stop, alarm
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in || state_reg == S500_CLEAR) begin
      col_reg <= 7'h00;
      tab_reg <= 4'h0;
      stop_reg <= 1'b0;
      pfc_reg <= 6'h00;
      ch_reg <= '0;
      if (!rst_b_in) alarm_reg <= 1'b0;
    end else if (state_reg == S501_FIRST && accept) begin
      pfc_reg <= in_ch.code;
    end else if (state_reg == S502_WAIT && accept) begin
      ch_reg <= in_ch;
      if (in_ch.code == CODE_STOP) begin
        stop_reg <= 1'b1;
      end else if (in_ch.code == CODE_SPACE) begin
        col_reg <= col_reg + 7'h01;
      end else if (in_ch.code == CODE_TAB) begin
        if (tab_reg == LAST_TAB) begin
          col_reg <= LINE_END;
        end else if (plug_reg[tab_reg] == 7'h00) begin
          alarm_reg <= 1'b1; // Empty socket
        end else begin
          col_reg <= plug_reg[tab_reg] - 7'h01;
          tab_reg <= tab_reg + 4'h1;
        end
      end
    end else if (state_reg == S504_WRITE) begin
      col_reg <= col_reg + 7'h01;
    end
  end

  // Static register: merge on read-in, compare on print
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      isr_reg <= 14'h0000;
      ofr_reg <= 2'h0;
    end else if (state_reg == S503_READ) begin
      ofr_reg <= 2'h0;
      isr_reg <= mem[col_of(col_reg)][13:0];
      if (col_reg >= HALF) isr_reg[13:7] <= ch_reg;
      else isr_reg[6:0] <= ch_reg;
    end else if (state_reg == S601_SCAN) begin
      isr_reg <= mem[idx_reg][13:0];
      ofr_reg <= 2'h0;
      if (hit(mem[idx_reg][6:0], drum_reg)) begin
        ofr_reg[0] <= 1'b1;
        isr_reg[6:0] <= 7'h00;
      end
      if (hit(mem[idx_reg][13:7], drum_reg)) begin
        ofr_reg[1] <= 1'b1;
        isr_reg[13:7] <= 7'h00;
      end
    end
  end

  // Core plane writes: clear, store, write back
  always_ff @(posedge sys_clk_in) begin
    if (state_reg == S500_CLEAR) begin
      mem[idx_reg] <= 16'h0000;
    end else if (state_reg == S504_WRITE) begin
      mem[col_of(col_reg)] <= {ofr_reg, isr_reg};
    end else if (state_reg == S602_BACK) begin
      mem[idx_reg] <= {ofr_reg, isr_reg};
    end
  end

  // Scan column; wraps to zero after each full pass
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) idx_reg <= 6'h00;
    else if (state_reg == S500_CLEAR || state_reg == S602_BACK) idx_reg <= idx_reg + 6'h01;
  end

  // Drum counter tracks the printer; revolution pulse resyncs it
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) drum_reg <= 6'h00;
    else drum_reg <= drum_next;
  end

  // Remember where on the drum the print started
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) first_reg <= 6'h00;
    else if (state_reg == S600_REST) first_reg <= drum_next;
  end

  // Hammers fire for one cycle on the drum sync
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in || state_reg != S603_FIRE || !rise[SY_CHAR]) begin
      hammer_reg <= '0;
    end else begin
      for (int h = 0; h < COLS; h++) begin
        hammer_reg[h] <= mem[h][ROW_LO];
        if (h < HAM_HI) hammer_reg[h + COLS] <= mem[h][ROW_HI];
      end
    end
  end

  // Paper feed: counted lines, page bottom, tail lines
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      lc_reg <= 6'h00;
      rem_reg <= 6'h00;
      page_reg <= 1'b0;
      tail_reg <= 1'b0;
    end else if (state_reg == S700_SET || state_reg == S800_SET || state_reg == S900_SET) begin
      tail_reg <= 1'b0;
      page_reg <= state_reg == S800_SET;
      rem_reg <= (state_reg == S900_SET) ? pfc_reg : {5'h00, ctrl_reg[CT_DBL]} + 6'h01;
    end else if (feed_out && lf) begin
      if (tail_reg) begin
        rem_reg <= rem_reg - 6'h01;
        if (fin) lc_reg <= 6'h00;
      end else if (bottom) begin
        lc_reg <= lc_inc;
        tail_reg <= 1'b1;
        rem_reg <= {4'h0, ctrl_reg[CT_EXTRA +: 2]} + 6'h01;
      end else begin
        lc_reg <= lc_inc;
        rem_reg <= rem_reg - 6'h01;
      end
    end
  end

  // Bus slave: read data latched at address phase, writes in data phase
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rdata_reg <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite_in && haddr_in[31:8] == 24'h00_0000;
      wr_addr_reg <= haddr_in[7:0];
      if (take && !hwrite_in) rdata_reg <= rd_mux(haddr_in);
    end
  end

  // Writable registers: mode switches and tab plugs
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= CTRL_RST;
      for (int i = 0; i < PLUGS; i++) plug_reg[i] <= 7'h00;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == OFS_CTRL) begin
        ctrl_reg <= hwdata_in[9:0];
      end else if (wr_addr_reg >= OFS_PLUG && wr_addr_reg < OFS_PLUG_END && wr_addr_reg[1:0] == 2'h0) begin
        plug_reg[4'(wr_addr_reg[7:2] - OFS_PLUG[7:2])] <= hwdata_in[6:0];
      end
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence store_seq;
    state_reg == S503_READ ##1 state_reg == S504_WRITE;
  endsequence

  tab_force_a: assert property (
    state_reg == S502_WAIT && accept && in_ch.code == CODE_TAB && tab_reg == LAST_TAB
    |=> col_reg == LINE_END ##1 state_reg == (pfm ? S900_SET : S600_REST))
    else $error("sixteenth tab did not end line");
  col_advance_a: assert property (
    store_seq |=> col_reg == $past(col_reg, 2) + 7'h01)
    else $error("column not advanced after store");
  first_copy_a: assert property (
    state_reg == S600_REST && state_next == S601_SCAN |=> first_reg == drum_reg)
    else $error("first character not copied");
  print_end_a: assert property (
    state_reg == S604_CHECK && drum_reg == first_reg |=> state_reg != S601_SCAN)
    else $error("print did not end on coincidence");
  hammer_when_a: assert property (
    |hammer_out |-> $past(state_reg) == S603_FIRE && $past(rise[SY_CHAR]))
    else $error("hammers fired outside drum sync");
  paper_rest_a: assert property (
    state_reg == S600_REST && s2_reg[SY_MOVE] |=> state_reg == S600_REST)
    else $error("print started while paper moving");
  halt_hold_a: assert property (
    state_reg == S802_HALT && !rise[SY_MAN] |=> state_reg == S802_HALT)
    else $error("halt left without manual reset");
  drum_step_a: assert property (
    rise[SY_CHAR] && !rise[SY_REV] |=> drum_reg == $past(drum_reg) + 6'h01)
    else $error("drum counter missed a sync");
  flag_clear_a: assert property (
    state_reg == S602_BACK && ofr_reg[0] |-> isr_reg[6:0] == 7'h00 ##1 mem[$past(idx_reg)][ROW_LO])
    else $error("output flag set without clearing half");
  cr_end_a: assert property (
    state_reg == S502_WAIT && accept && in_ch.code == CODE_CR
    |=> state_reg == S600_REST || state_reg == S900_SET)
    else $error("carriage return did not end read-in");
endmodule
`default_nettype wire

/* verification/lpb_printer.sv */
// Behavioural drum printer: drum syncs, line feed pulses and paper motion
`timescale 1ns/1ps
`default_nettype none
module lpb_printer (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic feed_in,
  output logic char_sync_out,
  output logic rev_sync_out,
  output logic line_fed_out,
  output logic paper_moving_out
);
  int tick; // Cycles within one character slot
  int slot; // Drum character slot, 64 per revolution
  int ftick; // Cycles within one 60-cycle feed period, zero when not feeding
  int rest; // Settling cycles after feed stops
  // Drum turns free; slots kept 150 cycles apart
  always @(posedge sys_clk_in) begin
    tick <= (tick == 149) ? 0 : tick + 1;
    if (tick == 149) begin
      slot <= (slot == 63) ? 0 : slot + 1;
    end
    char_sync_out <= (tick < 4);
    rev_sync_out <= (tick < 4) && (slot == 0);
  end
  // Paper feeds while asked, one pulse each 60 cycles, then settles
  always @(posedge sys_clk_in) begin
    ftick <= feed_in ? ((ftick == 59) ? 0 : ftick + 1) : 0;
    line_fed_out <= feed_in && (ftick >= 55);
    rest <= feed_in ? 30 : ((rest > 0) ? rest - 1 : 0);
    paper_moving_out <= feed_in || (rest > 0);
  end
  initial begin
    tick = 0;
    slot = 0;
    ftick = 0;
    rest = 0;
    char_sync_out = 1'b0;
    rev_sync_out = 1'b0;
    line_fed_out = 1'b0;
    paper_moving_out = 1'b0;
  end
endmodule
`default_nettype wire

/* verification/lpb_top_tb_top.sv */
// Testbench for the line printer buffer: bus, character link and printer
`timescale 1ns/1ps
`default_nettype none
module lpb_top_tb_top;
  import lpb_pkg::*;
  logic sys_clk_in, rst_b_in, hsel_in, hwrite_in, char_valid_in, manual_reset_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in;
  wire logic hreadyout_out, hresp_out, char_ready_out, feed_out;
  wire logic char_sync, rev_sync, line_fed, paper_moving;
  wire logic [HAM-1:0] hammer_out;
  lpb_in_char_t char_in;
  logic [HAM-1:0] fired, twice; // Hammers seen firing, and fired more than once
  logic clr; // Clears the hammer record
  int fails, samples_checked, cyc;
  lpb_top dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .char_in(char_in), .char_valid_in(char_valid_in),
    .char_ready_out(char_ready_out), .char_sync_in(char_sync), .rev_sync_in(rev_sync),
    .line_fed_in(line_fed), .paper_moving_in(paper_moving), .manual_reset_in(manual_reset_in),
    .feed_out(feed_out), .hammer_out(hammer_out));
  lpb_printer prn (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .feed_in(feed_out),
    .char_sync_out(char_sync), .rev_sync_out(rev_sync), .line_fed_out(line_fed),
    .paper_moving_out(paper_moving));
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  // Record hammer pulses; a double fire means a match was not cleared
  always @(posedge sys_clk_in) begin
    fired <= clr ? '0 : (fired | hammer_out);
    twice <= clr ? '0 : (twice | (fired & hammer_out));
  end
  // Hang guard: three lines with full drum turns fit well inside this
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      close_out();
    end
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Single word transfer; address held until hready, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'b10;
    hwrite_in <= wr;
    haddr_in <= a;
    do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'b00;
    hsel_in <= 1'b0;
    hwdata_in <= d;
    do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check({96'h0, rd & m}, {96'h0, e});
  endtask
  // Converter handshake: valid held until taken with ready
  task automatic send(input logic [5:0] c);
    @(posedge sys_clk_in);
    char_in <= '{code: c, ctl: 1'b0, par: 1'b1};
    char_valid_in <= 1'b1;
    do @(posedge sys_clk_in); while (char_ready_out !== 1'b1);
    char_valid_in <= 1'b0;
  endtask
  task automatic wait_ready();
    do @(negedge sys_clk_in); while (char_ready_out !== 1'b1);
  endtask
  initial begin
    cyc = 0;
    fails = 0;
    samples_checked = 0;
    rst_b_in = 1'b0;
    hsel_in = 1'b0;
    htrans_in = 2'b00;
    hwrite_in = 1'b0;
    hsize_in = 3'h2;
    haddr_in = 32'h0;
    hwdata_in = 32'h0;
    char_in = '0;
    char_valid_in = 1'b0;
    manual_reset_in = 1'b0;
    clr = 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    rd_chk(32'h0, 32'h3ff, 32'h0); // Control register at reset
    rd_chk(32'h44, 32'hffffffff, 32'h0); // Empty tab socket
    bus(1'b1, 32'h20, 32'h5a5a5a5a);
    rd_chk(32'h20, 32'hffffffff, 32'h0); // Unmapped place
    bus(1'b1, 32'h0, 32'h0000000c); // Auto feed, single, three lines a page
    rd_chk(32'h0, 32'h3ff, 32'h0000000c);
    bus(1'b1, 32'h40, 32'd70); // First tab to position 70
    wait_ready();
    check({127'h0, hammer_out == '0}, 128'h1);
    send(6'h06);
    send(CODE_SPACE);
    send(6'h07);
    send(CODE_TAB);
    send(6'h08);
    wait_ready();
    rd_chk(32'h4, 32'h7f0f0000, {1'b0, 7'd70, 4'h0, 4'h1, 16'h0});
    send(CODE_TAB);
    rd_chk(32'h4, 32'h00200000, 32'h00200000); // Second socket empty
    @(posedge sys_clk_in);
    clr <= 1'b0;
    send(CODE_CR);
    wait_ready();
    check({8'h0, fired}, {8'h0, 120'h1 << 69 | 120'h5});
    check({8'h0, twice}, 128'h0);
    rd_chk(32'h4, 32'h00003f00, 32'h00000100);
    clr <= 1'b1;
    @(posedge sys_clk_in);
    clr <= 1'b0;
    send(6'h09);
    send(CODE_STOP);
    do @(posedge sys_clk_in); while (feed_out !== 1'b1);
    check({8'h0, fired}, 128'h1);
    do bus(1'b0, 32'h4, 32'h0); while (rd[6:0] !== S802_HALT && cyc < 80000);
    rd_chk(32'h4, 32'h00103f7f, {11'h0, 1'b1, 12'h0, 1'b0, S802_HALT});
    check({127'h0, feed_out}, 128'h0);
    repeat (40) @(posedge sys_clk_in);
    rd_chk(32'h4, 32'h7f, {25'h0, S802_HALT});
    bus(1'b1, 32'h0, 32'h0000000d); // Programmed feed, three lines a page
    for (int i = 1; i < PLUGS; i++) bus(1'b1, 32'h40 + 32'(4 * i), 32'(70 + i)); // Fill sockets 2 to 15
    manual_reset_in <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    manual_reset_in <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    bus(1'b0, 32'h4, 32'h0);
    check({127'h0, rd[6:0] != S802_HALT}, 128'h1);
    // Programmed line: count, one character, sixteen tabs end the line
    clr <= 1'b1;
    wait_ready();
    clr <= 1'b0;
    send(6'h02);
    send(6'h0a);
    repeat (16) send(CODE_TAB);
    do @(posedge sys_clk_in); while (feed_out !== 1'b1);
    check({8'h0, fired}, 128'h0);
    wait_ready();
    check({8'h0, fired}, 128'h1);
    rd_chk(32'h4, 32'h00003f00, 32'h00000200);
    close_out();
  end
endmodule
`default_nettype wire
